// ===== include/ccr_pkg.sv
// Constants for the channel context receive control block.
package ccr_pkg;
  // Register byte offsets on the Wishbone slave.
  localparam logic [3:0] REG_CTRL_OFS    = 4'h0;
  localparam logic [3:0] REG_STATUS_OFS  = 4'h4;
  localparam logic [3:0] REG_ACCEPT_OFS  = 4'h8;
  localparam logic [3:0] REG_DROP_OFS    = 4'hc;
  // Control register fields and reset value.
  localparam int         CTRL_IRQ_MASTER = 0;
  localparam int         CTRL_SMALL_TBL  = 1;
  localparam logic [1:0] CTRL_RESET      = 2'h0;
  // Status register fields.
  localparam int         STAT_LAST_ACC   = 0;
  localparam int         STAT_LAST_DROP  = 1;
  localparam int         STAT_LAST_MISS  = 2;
  localparam int         STAT_LAST_ERR   = 3;
  // Context entry word 0 fields.
  localparam int         W0_JUMP_EN      = 13;
  // Context entry word offset 10: next entry pointer field.
  localparam int         W10_PTR_HI      = 15;
  localparam int         W10_PTR_LO      = 3;
  // Context entry word offset 12 receive control bits.
  localparam int         W12_RX_READY    = 15;
  localparam int         W12_RX_CONG     = 14;
  localparam int         W12_RX_MISS     = 13;
  localparam int         W12_RAW_PASS    = 11;
  localparam int         W12_IRQ_DIS     = 10;
  localparam int         W12_ACCEPT_ERR  = 9;
  localparam int         W12_KEEP_FCS    = 8;
  // Context entry word offset 14: shared ring enable and pointer.
  localparam int         W14_SHARE_EN    = 0;
  localparam int         W14_PTR_HI      = 15;
  localparam int         W14_PTR_LO      = 3;
  // Word offset 16: current receive descriptor slot in bits 15:9.
  localparam int         W16_SLOT_HI     = 15;
  localparam int         W16_SLOT_LO     = 9;
  // Address field bit positions, first octet in bits 31:24.
  localparam int         ADDR_CR         = 25;
  localparam int         ADDR_FECN       = 19;
  localparam int         ADDR_BECN       = 18;
  localparam int         ADDR_DE         = 17;
  // Address field length limits in octets.
  localparam logic [2:0] ADDR_MIN_OCT    = 3'h2;
  localparam logic [2:0] ADDR_MAX_OCT    = 3'h4;
  // Widths.
  localparam int         IDX_W           = 13;
  localparam int         SLOT_W          = 7;
  localparam int         BASE_W          = 24;
  localparam int         CNT_W           = 16;
endpackage : ccr_pkg

// ===== verilog/ccr_rx_ctrl.sv
// Receive-side channel context entry control with a Wishbone slave.
//
// How it works
// - Accept address fields of two to four octets.
// - Management channel sends address field unaltered.
// - Ordinary channels take congestion bits from descriptor.
// - Copy congestion bits to rx word0, not management.
// - Use next pointer only when jump is enabled.
// - Next pointer uses all thirteen index bits.
// - Channel not ready discards every frame.
// - Congestion drops DE frames and counts them.
// - Set miss flag when not ready or unowned.
// - Miss raises interrupt when master enable set.
// - Raw pass keeps header, congestion bits untouched.
// - Interrupt disable suppresses receive interrupts.
// - Accept errored frames and flag them.
// - Keep checksum stores frame check after data.
// - Shared ring uses pointed entry slot and base.
// - Shared ring updates pointed entry congestion counts.
// - Shared pointer uses all thirteen index bits.
// - Slot field holds index zero to 127.
// - Count FECN frames while channel is ready.
// - Receive only when active and ready.
// - Jump enable selects pointed entry next.
`timescale 1ns/1ns
module ccr_rx_ctrl #(
  parameter int CNT_WIDTH = ccr_pkg::CNT_W
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RST_N,
  // Wishbone classic slave.
  input  wire logic                          CYC_I,
  input  wire logic                          STB_I,
  input  wire logic                          WE_I,
  input  wire logic [3:0]                    ADR_I,
  input  wire logic [3:0]                    SEL_I,
  input  wire logic [31:0]                   DAT_I,
  output logic [31:0]                        DAT_O,
  output logic                               ACK_O,
  // Context entry words fetched by the DMA engine for the current entry.
  input  wire logic [ccr_pkg::IDX_W-1:0]     CUR_ENTRY_IDX,
  input  wire logic [15:0]                   CTX_W0,
  input  wire logic [15:0]                   CTX_W10,
  input  wire logic [15:0]                   CTX_W12,
  input  wire logic [15:0]                   CTX_W14,
  input  wire logic [15:0]                   CTX_W16,
  input  wire logic [15:0]                   CTX_W18,
  input  wire logic [31:0]                   CTX_ADDR,
  // Ring words of the entry named by the shared ring pointer.
  input  wire logic [15:0]                   SHR_W16,
  input  wire logic [15:0]                   SHR_W18,
  // Entry service finished; asks for the next entry index.
  input  wire logic                          ENTRY_DONE,
  // Transmit header build request.
  input  wire logic                          TX_HDR_REQ,
  input  wire logic                          TX_IS_MGMT,
  input  wire logic [3:0]                    TX_DESC_BITS,
  // Received frame report from the deframer.
  input  wire logic                          FRM_VALID,
  input  wire logic                          FRM_IS_MGMT,
  input  wire logic [2:0]                    FRM_ADDR_OCTETS,
  input  wire logic [31:0]                   FRM_ADDR,
  input  wire logic                          FRM_ABORTED,
  input  wire logic                          FRM_BAD_FCS,
  input  wire logic                          FRM_TABLE_ACTIVE,
  input  wire logic                          FRM_BUF_OWNED,
  // Next entry selection.
  output logic                               NEXT_VALID,
  output logic [ccr_pkg::IDX_W-1:0]          NEXT_ENTRY_IDX,
  // Transmit address field.
  output logic                               TX_HDR_VALID,
  output logic [31:0]                        TX_ADDR,
  // Receive decision.
  output logic                               RX_ACCEPT,
  output logic                               RX_DISCARD,
  output logic                               RX_WORD0_CONG_WE,
  output logic [3:0]                         RX_WORD0_CONG,
  output logic                               RX_FRAME_ERROR,
  output logic                               RX_KEEP_HEADER,
  output logic                               RX_STORE_FCS,
  output logic [ccr_pkg::IDX_W-1:0]          RING_ENTRY_IDX,
  output logic [ccr_pkg::SLOT_W-1:0]         RING_SLOT,
  output logic [ccr_pkg::BASE_W-1:0]         RING_BASE,
  // Context write-back and counter strobes.
  output logic                               MISS_SET,
  output logic [15:0]                        CTX_W12_OUT,
  output logic                               FECN_CNT_INC,
  output logic                               DISCARD_CNT_INC,
  output logic                               RX_CONG_CNT_INC,
  output logic [ccr_pkg::IDX_W-1:0]          CONG_CNT_IDX,
  // Event pulses towards the interrupt ring writer.
  output logic                               MISS_IRQ,
  output logic                               RX_IRQ
);

  // Control register: interrupt master enable and table size select.
  logic [1:0]            ctrl_reg;
  // Last decision flags shown to software.
  logic [3:0]            status_reg;
  // Accepted and dropped frame counts.
  logic [CNT_WIDTH-1:0]  accept_cnt_reg;
  logic [CNT_WIDTH-1:0]  drop_cnt_reg;
  logic                  ack_reg;
  logic [31:0]           dat_reg;

  // Bus request taken in the cycle before the acknowledge.
  logic                  bus_req;
  logic                  bus_wr;
  assign bus_req = CYC_I & STB_I & ~ack_reg;
  assign bus_wr  = bus_req & WE_I;

  // Context bit views of the current entry.
  logic                  ready;
  logic                  congested;
  logic                  raw_pass;
  logic                  irq_dis;
  logic                  accept_err;
  logic                  keep_fcs;
  logic                  share_en;
  logic                  errored;
  logic                  de_bit;
  logic                  len_ok;
  assign ready      = CTX_W12[ccr_pkg::W12_RX_READY];
  assign congested  = CTX_W12[ccr_pkg::W12_RX_CONG];
  assign raw_pass   = CTX_W12[ccr_pkg::W12_RAW_PASS];
  assign irq_dis    = CTX_W12[ccr_pkg::W12_IRQ_DIS];
  assign accept_err = CTX_W12[ccr_pkg::W12_ACCEPT_ERR];
  assign keep_fcs   = CTX_W12[ccr_pkg::W12_KEEP_FCS];
  assign share_en   = CTX_W14[ccr_pkg::W14_SHARE_EN];
  assign errored    = FRM_ABORTED | FRM_BAD_FCS;
  assign de_bit     = FRM_ADDR[ccr_pkg::ADDR_DE];
  // Any length from two up to four octets is a legal address field.
  assign len_ok     = (FRM_ADDR_OCTETS >= ccr_pkg::ADDR_MIN_OCT) &&
                      (FRM_ADDR_OCTETS <= ccr_pkg::ADDR_MAX_OCT);

  // Receive decision, decided combinationally and registered below.
  logic                  live;
  logic                  miss_next;
  logic                  cong_drop;
  logic                  err_drop;
  logic                  accept_next;
  assign live        = FRM_VALID & FRM_TABLE_ACTIVE & len_ok;
  // Missing readiness or a buffer both count as a miss.
  assign miss_next   = live & (~ready | ~FRM_BUF_OWNED);
  assign err_drop    = live & ready & errored & ~accept_err;
  assign cong_drop   = live & ready & ~err_drop & congested &
                       de_bit;
  assign accept_next = live & ready & FRM_BUF_OWNED & ~err_drop &
                       ~cong_drop;

  // Wishbone acknowledge: one cycle after the request is seen.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Read data mux; an unmapped offset reads as zero.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      dat_reg <= 32'h0;
    end else if (bus_req && !WE_I) begin
      case (ADR_I)
        ccr_pkg::REG_CTRL_OFS:   dat_reg <= {30'h0, ctrl_reg};
        ccr_pkg::REG_STATUS_OFS: dat_reg <= {28'h0, status_reg};
        ccr_pkg::REG_ACCEPT_OFS: dat_reg <= 32'(accept_cnt_reg);
        ccr_pkg::REG_DROP_OFS:   dat_reg <= 32'(drop_cnt_reg);
        default:                 dat_reg <= 32'h0;
      endcase
    end
  end

  // Control register write through the low byte lane.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ctrl_reg <= ccr_pkg::CTRL_RESET;
    end else if (bus_wr && SEL_I[0] && ADR_I == ccr_pkg::REG_CTRL_OFS) begin
      ctrl_reg <= DAT_I[1:0];
    end
  end

  // Frame counters; a write of any value to a counter clears it, and a
  // frame event in the same cycle wins so no count is lost.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      accept_cnt_reg <= '0;
      drop_cnt_reg   <= '0;
    end else begin
      if (accept_next) begin
        accept_cnt_reg <= accept_cnt_reg + 1'b1;
      end else if (bus_wr && ADR_I == ccr_pkg::REG_ACCEPT_OFS) begin
        accept_cnt_reg <= '0;
      end
      if (live && !accept_next) begin
        drop_cnt_reg <= drop_cnt_reg + 1'b1;
      end else if (bus_wr && ADR_I == ccr_pkg::REG_DROP_OFS) begin
        drop_cnt_reg <= '0;
      end
    end
  end

  // Status keeps the flags of the most recent live frame.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      status_reg <= 4'h0;
    end else if (live) begin
      status_reg[ccr_pkg::STAT_LAST_ACC]  <= accept_next;
      status_reg[ccr_pkg::STAT_LAST_DROP] <= ~accept_next;
      status_reg[ccr_pkg::STAT_LAST_MISS] <= miss_next;
      status_reg[ccr_pkg::STAT_LAST_ERR]  <= errored;
    end
  end

  // Next entry: the pointer field is used whole as a table index, so the
  // small table select bit has no say here.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      NEXT_VALID     <= 1'b0;
      NEXT_ENTRY_IDX <= '0;
    end else begin
      NEXT_VALID <= ENTRY_DONE;
      if (ENTRY_DONE) begin
        if (CTX_W0[ccr_pkg::W0_JUMP_EN]) begin
          NEXT_ENTRY_IDX <=
            CTX_W10[ccr_pkg::W10_PTR_HI:ccr_pkg::W10_PTR_LO];
        end else begin
          NEXT_ENTRY_IDX <= CUR_ENTRY_IDX + 1'b1;
        end
      end
    end
  end

  // Transmit address field; on ordinary channels the descriptor bits
  // overwrite the context bits at the FECN, BECN, DE and CR positions.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      TX_HDR_VALID <= 1'b0;
      TX_ADDR      <= 32'h0;
    end else begin
      TX_HDR_VALID <= TX_HDR_REQ;
      if (TX_HDR_REQ) begin
        if (TX_IS_MGMT) begin
          TX_ADDR <= CTX_ADDR;
        end else begin
          TX_ADDR <= CTX_ADDR;
          TX_ADDR[ccr_pkg::ADDR_FECN] <= TX_DESC_BITS[3];
          TX_ADDR[ccr_pkg::ADDR_BECN] <= TX_DESC_BITS[2];
          TX_ADDR[ccr_pkg::ADDR_DE]   <= TX_DESC_BITS[1];
          TX_ADDR[ccr_pkg::ADDR_CR]   <= TX_DESC_BITS[0];
        end
      end
    end
  end

  // Receive decision strobes, one cycle after the frame report.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RX_ACCEPT  <= 1'b0;
      RX_DISCARD <= 1'b0;
    end else begin
      RX_ACCEPT  <= accept_next;
      RX_DISCARD <= FRM_VALID & ~accept_next;
    end
  end

  // Receive descriptor word 0 content for accepted frames.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RX_WORD0_CONG_WE <= 1'b0;
      RX_WORD0_CONG    <= 4'h0;
      RX_FRAME_ERROR   <= 1'b0;
      RX_KEEP_HEADER   <= 1'b0;
      RX_STORE_FCS     <= 1'b0;
    end else begin
      // Raw pass and the management channel leave these bits alone.
      RX_WORD0_CONG_WE <= accept_next & ~FRM_IS_MGMT & ~raw_pass;
      RX_WORD0_CONG    <= {FRM_ADDR[ccr_pkg::ADDR_FECN],
                           FRM_ADDR[ccr_pkg::ADDR_BECN],
                           FRM_ADDR[ccr_pkg::ADDR_DE],
                           FRM_ADDR[ccr_pkg::ADDR_CR]};
      RX_FRAME_ERROR   <= accept_next & errored;
      RX_KEEP_HEADER   <= accept_next & raw_pass;
      RX_STORE_FCS     <= accept_next & keep_fcs;
    end
  end

  // Ring selection: a shared ring borrows slot and base from the entry the
  // shared pointer names, taken whole as a thirteen bit index.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RING_ENTRY_IDX <= '0;
      RING_SLOT      <= '0;
      RING_BASE      <= '0;
    end else if (FRM_VALID) begin
      if (share_en) begin
        RING_ENTRY_IDX <=
          CTX_W14[ccr_pkg::W14_PTR_HI:ccr_pkg::W14_PTR_LO];
        RING_SLOT <=
          SHR_W16[ccr_pkg::W16_SLOT_HI:ccr_pkg::W16_SLOT_LO];
        // Bit 0 is forced low since the base is a word address.
        RING_BASE <= {SHR_W16[7:0], SHR_W18[15:1], 1'b0};
      end else begin
        RING_ENTRY_IDX <= CUR_ENTRY_IDX;
        RING_SLOT <=
          CTX_W16[ccr_pkg::W16_SLOT_HI:ccr_pkg::W16_SLOT_LO];
        RING_BASE <= {CTX_W16[7:0], CTX_W18[15:1], 1'b0};
      end
    end
  end

  // Miss flag write-back of the receive control word.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      MISS_SET    <= 1'b0;
      CTX_W12_OUT <= 16'h0;
    end else begin
      MISS_SET <= miss_next;
      if (miss_next) begin
        CTX_W12_OUT <= CTX_W12 | (16'h1 << ccr_pkg::W12_RX_MISS);
      end
    end
  end

  // Counter strobes; congestion counts go to the shared entry if any.
  // Congestion may also drop raw-pass frames; the host keeps it clear.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      FECN_CNT_INC    <= 1'b0;
      DISCARD_CNT_INC <= 1'b0;
      RX_CONG_CNT_INC <= 1'b0;
      CONG_CNT_IDX    <= '0;
    end else begin
      FECN_CNT_INC    <= live & ready & FRM_ADDR[ccr_pkg::ADDR_FECN];
      DISCARD_CNT_INC <= cong_drop;
      RX_CONG_CNT_INC <= accept_next;
      if (FRM_VALID) begin
        CONG_CNT_IDX <= share_en ?
          CTX_W14[ccr_pkg::W14_PTR_HI:ccr_pkg::W14_PTR_LO] :
          CUR_ENTRY_IDX;
      end
    end
  end

  // Event pulses for the interrupt ring writer.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      MISS_IRQ <= 1'b0;
      RX_IRQ   <= 1'b0;
    end else begin
      MISS_IRQ <= miss_next & ctrl_reg[ccr_pkg::CTRL_IRQ_MASTER];
      RX_IRQ   <= accept_next & ~irq_dis;
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;

endmodule : ccr_rx_ctrl

// ===== sim/ccr_rx_ctrl_asserts.sv
// Concurrent checks on the ports of the receive context control block.
`timescale 1ns/1ns
module ccr_rx_ctrl_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic [15:0] CTX_W0,
  input wire logic [15:0] CTX_W10,
  input wire logic [15:0] CTX_W12,
  input wire logic [15:0] CTX_W14,
  input wire logic [31:0] CTX_ADDR,
  input wire logic [15:0] SHR_W16,
  input wire logic        ENTRY_DONE,
  input wire logic        TX_HDR_REQ,
  input wire logic        TX_IS_MGMT,
  input wire logic        FRM_VALID,
  input wire logic        FRM_IS_MGMT,
  input wire logic [2:0]  FRM_ADDR_OCTETS,
  input wire logic [31:0] FRM_ADDR,
  input wire logic        FRM_ABORTED,
  input wire logic        FRM_BAD_FCS,
  input wire logic        FRM_TABLE_ACTIVE,
  input wire logic        NEXT_VALID,
  input wire logic [12:0] NEXT_ENTRY_IDX,
  input wire logic        TX_HDR_VALID,
  input wire logic [31:0] TX_ADDR,
  input wire logic        RX_ACCEPT,
  input wire logic        RX_DISCARD,
  input wire logic        RX_WORD0_CONG_WE,
  input wire logic        RX_KEEP_HEADER,
  input wire logic        RX_STORE_FCS,
  input wire logic [12:0] RING_ENTRY_IDX,
  input wire logic [6:0]  RING_SLOT,
  input wire logic        MISS_SET,
  input wire logic [15:0] CTX_W12_OUT,
  input wire logic        FECN_CNT_INC,
  input wire logic        DISCARD_CNT_INC,
  input wire logic        MISS_IRQ,
  input wire logic        RX_IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // A frame that passed lookup and carries a legal address length.
  sequence live_s;
    FRM_VALID && FRM_TABLE_ACTIVE && FRM_ADDR_OCTETS >= 3'h2 &&
    FRM_ADDR_OCTETS <= 3'h4;
  endsequence
  // A live frame on a channel that is ready to receive.
  sequence ready_s;
    live_s ##0 CTX_W12[15];
  endsequence
  inactive_drop_a: assert property (
    FRM_VALID && !FRM_TABLE_ACTIVE |=> RX_DISCARD && !MISS_SET)
    else $error("Inactive entry frame was not dropped quietly.");
  not_ready_a: assert property (
    (live_s ##0 !CTX_W12[15]) |=> RX_DISCARD && MISS_SET && CTX_W12_OUT[13])
    else $error("Frame for a closed channel was not missed.");
  cong_drop_a: assert property (
    (ready_s ##0 (CTX_W12[14] && FRM_ADDR[17] && !FRM_ABORTED &&
    !FRM_BAD_FCS)) |=> RX_DISCARD && DISCARD_CNT_INC)
    else $error("Eligible frame survived congestion.");
  fecn_count_a: assert property (
    (ready_s ##0 FRM_ADDR[19]) |=> FECN_CNT_INC)
    else $error("Forward congestion frame not counted.");
  jump_index_a: assert property (
    ENTRY_DONE && CTX_W0[13] |=>
    NEXT_VALID && NEXT_ENTRY_IDX == $past(CTX_W10[15:3]))
    else $error("Jump did not select the pointed entry.");
  mgmt_tx_addr_a: assert property (
    TX_HDR_REQ && TX_IS_MGMT |=> TX_HDR_VALID && TX_ADDR == $past(CTX_ADDR))
    else $error("Management address field was altered.");
  irq_disable_a: assert property (
    FRM_VALID && CTX_W12[10] |=> !RX_IRQ)
    else $error("Receive interrupt raised while disabled.");
  accept_flags_a: assert property (
    RX_ACCEPT |-> RX_STORE_FCS == $past(CTX_W12[8]) &&
    RX_KEEP_HEADER == $past(CTX_W12[11]))
    else $error("Header or checksum handling wrong.");
  shared_ring_a: assert property (
    FRM_VALID && CTX_W14[0] |=> RING_ENTRY_IDX == $past(CTX_W14[15:3]) &&
    RING_SLOT == $past(SHR_W16[15:9]))
    else $error("Shared ring slot not taken from pointed entry.");
  mgmt_rx_a: assert property (
    FRM_VALID && FRM_IS_MGMT |=> !RX_WORD0_CONG_WE)
    else $error("Management frame wrote congestion bits.");
  miss_irq_a: assert property (
    MISS_IRQ |-> MISS_SET)
    else $error("Miss interrupt without a miss.");
endmodule : ccr_rx_ctrl_chk

// ===== sim/ccr_ctx_host.sv
// Host memory model that holds context entries and serves their words.
`timescale 1ns/1ns
module ccr_ctx_host (
  input  wire logic        core_clk,
  input  wire logic [12:0] cur_idx,
  input  wire logic        miss_set,
  output logic      [15:0] w0,
  output logic      [15:0] w10,
  output logic      [15:0] w12,
  output logic      [15:0] w14,
  output logic      [15:0] w16,
  output logic      [15:0] w18,
  output logic      [31:0] addr,
  output logic      [15:0] shr16,
  output logic      [15:0] shr18
);
  // Sixteen entries of eight words; words 6 and 7 hold the address field.
  logic [15:0] mem_reg [16][8];
  logic [3:0]  cur;  // Slot of the current entry.
  logic [3:0]  shr;  // Slot named by the shared ring pointer.
  // Only four index bits are stored, so far pointers alias to low slots.
  assign cur = cur_idx[3:0];
  assign shr = mem_reg[cur][3][6:3];
  assign w0 = mem_reg[cur][0];
  assign w10 = mem_reg[cur][1];
  assign w12 = mem_reg[cur][2];
  assign w14 = mem_reg[cur][3];
  assign w16 = mem_reg[cur][4];
  assign w18 = mem_reg[cur][5];
  assign addr = {mem_reg[cur][6], mem_reg[cur][7]};
  assign shr16 = mem_reg[shr][4];
  assign shr18 = mem_reg[shr][5];
  // Entries start cleared: slot zero and congestion off.
  initial begin
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 8; j++) begin
        mem_reg[i][j] = 16'h0000;
      end
    end
  end
  // The host clears the miss flag once the device has reported it.
  always @(posedge core_clk) begin
    if (miss_set) begin
      mem_reg[cur][2][13] <= 1'b0;
    end
  end
  // Host write of one word; ring bases are kept word aligned.
  task automatic put(input logic [3:0] i, input int w,
                     input logic [15:0] v);
    mem_reg[i][w] <= (w == 5) ? {v[15:1], 1'b0} : v;
  endtask : put
endmodule : ccr_ctx_host

// ===== sim/ccr_rx_ctrl_tb_top.sv
// Self-checking bench for the receive context control block.
`timescale 1ns/1ns
module ccr_rx_ctrl_tb_top;
  logic        CORE_CLK, RST_N, CYC_I, STB_I, WE_I, ACK_O, ENTRY_DONE;
  logic        TX_HDR_REQ, TX_IS_MGMT, FRM_VALID, FRM_IS_MGMT, FRM_ABORTED;
  logic        FRM_BAD_FCS, FRM_TABLE_ACTIVE, FRM_BUF_OWNED, NEXT_VALID;
  logic        TX_HDR_VALID, RX_ACCEPT, RX_DISCARD, RX_WORD0_CONG_WE;
  logic        RX_FRAME_ERROR, RX_KEEP_HEADER, RX_STORE_FCS, MISS_SET;
  logic        FECN_CNT_INC, DISCARD_CNT_INC, RX_CONG_CNT_INC;
  logic        MISS_IRQ, RX_IRQ;
  logic [3:0]  ADR_I, SEL_I, TX_DESC_BITS, RX_WORD0_CONG;
  logic [2:0]  FRM_ADDR_OCTETS;
  logic [31:0] DAT_I, DAT_O, CTX_ADDR, FRM_ADDR, TX_ADDR, rd_data;
  logic [15:0] CTX_W0, CTX_W10, CTX_W12, CTX_W14, CTX_W16, CTX_W18;
  logic [15:0] SHR_W16, SHR_W18, CTX_W12_OUT;
  logic [12:0] CUR_ENTRY_IDX, NEXT_ENTRY_IDX, RING_ENTRY_IDX, CONG_CNT_IDX;
  logic [6:0]  RING_SLOT;
  logic [23:0] RING_BASE;
  int          fails, checks, cycles;  // Verdict counters and run clock.
  ccr_rx_ctrl dut_u (.*);
  ccr_ctx_host host_u (.core_clk(CORE_CLK), .cur_idx(CUR_ENTRY_IDX),
    .miss_set(MISS_SET), .w0(CTX_W0), .w10(CTX_W10), .w12(CTX_W12),
    .w14(CTX_W14), .w16(CTX_W16), .w18(CTX_W18), .addr(CTX_ADDR),
    .shr16(SHR_W16), .shr18(SHR_W18));
  // Free-running core clock, 50 ns period.
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One classic bus cycle; the request stands until ack is sampled.
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] d);
    @(posedge CORE_CLK);
    {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, we, adr, d};
    // No cycle count is assumed; only the bench timeout ends this wait.
    do begin
      @(posedge CORE_CLK);
    end while (ACK_O !== 1'b1);
    rd_data = DAT_O;
    chk("bus_ack", ACK_O, 1'b1);
    {CYC_I, STB_I} <= 2'b00;
  endtask : wb
  // One frame report; the decision is looked at in the answer cycle.
  task automatic frm(input logic [31:0] a, input logic [2:0] oct,
                     input logic [4:0] fl, input logic [2:0] ex);
    @(posedge CORE_CLK);
    {FRM_VALID, FRM_ADDR, FRM_ADDR_OCTETS} <= {1'b1, a, oct};
    {FRM_IS_MGMT, FRM_ABORTED, FRM_BAD_FCS, FRM_TABLE_ACTIVE,
     FRM_BUF_OWNED} <= fl;
    @(posedge CORE_CLK);
    FRM_VALID <= 1'b0;
    #1;
    chk("rx_result", {RX_ACCEPT, RX_DISCARD, MISS_SET}, ex);
  endtask : frm
  // Entry finished; the next index follows one cycle later.
  task automatic nxt(input logic [12:0] exp);
    @(posedge CORE_CLK);
    ENTRY_DONE <= 1'b1;
    @(posedge CORE_CLK);
    ENTRY_DONE <= 1'b0;
    #1;
    chk("next_idx", {NEXT_VALID, NEXT_ENTRY_IDX}, {1'b1, exp});
  endtask : nxt
  // Transmit header build for the current entry.
  task automatic tx(input logic m, input logic [31:0] exp);
    @(posedge CORE_CLK);
    {TX_HDR_REQ, TX_IS_MGMT} <= {1'b1, m};
    @(posedge CORE_CLK);
    TX_HDR_REQ <= 1'b0;
    #1;
    chk("tx_valid", TX_HDR_VALID, 1'b1);
    chk("tx_addr", TX_ADDR, exp);
  endtask : tx
  initial begin
    {CYC_I, STB_I, WE_I, ENTRY_DONE, TX_HDR_REQ, TX_IS_MGMT} = '0;
    {FRM_VALID, FRM_IS_MGMT, FRM_ABORTED, FRM_BAD_FCS} = '0;
    {FRM_TABLE_ACTIVE, FRM_BUF_OWNED, FRM_ADDR_OCTETS, FRM_ADDR} = '0;
    {ADR_I, DAT_I, CUR_ENTRY_IDX, RST_N, fails, checks, cycles} = '0;
    SEL_I = 4'hf;
    TX_DESC_BITS = 4'ha;
    repeat (12) @(posedge CORE_CLK);
    #1;
    chk("reset_out", {ACK_O, RX_ACCEPT, NEXT_VALID, TX_HDR_VALID}, 4'h0);
    @(posedge CORE_CLK);
    RST_N <= 1'b1;
    wb(1'b0, ccr_pkg::REG_CTRL_OFS, 32'h0);
    chk("ctrl_rst", rd_data, 32'h0);
    wb(1'b1, 4'h2, 32'hffffffff);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", rd_data, 32'h0);
    wb(1'b1, ccr_pkg::REG_CTRL_OFS, 32'h3);
    host_u.put(4'h0, 2, 16'h8000);
    host_u.put(4'h0, 4, 16'h0a12);
    host_u.put(4'h0, 5, 16'h3456);
    frm(32'h020a0000, 3'h4, 5'h03, 3'h4);
    chk("w0_cong", {RX_WORD0_CONG_WE, RX_WORD0_CONG}, 5'h1b);
    chk("fecn_inc", FECN_CNT_INC, 1'b1);
    chk("ring", {RING_SLOT, RING_BASE}, {7'h05, 24'h123456});
    chk("rx_irq", RX_IRQ, 1'b1);
    chk("cong_cnt", {RX_CONG_CNT_INC, CONG_CNT_IDX}, 14'h2000);
    frm(32'h10000000, 3'h5, 5'h03, 3'h2);
    frm(32'h10000000, 3'h2, 5'h01, 3'h2);
    frm(32'h020a0000, 3'h2, 5'h13, 3'h4);
    chk("mgmt_we", RX_WORD0_CONG_WE, 1'b0);
    wb(1'b1, ccr_pkg::REG_ACCEPT_OFS, 32'h0);
    wb(1'b1, ccr_pkg::REG_DROP_OFS, 32'h0);
    host_u.put(4'h0, 2, 16'hc000);
    frm(32'h00020000, 3'h2, 5'h03, 3'h2);
    chk("disc_inc", DISCARD_CNT_INC, 1'b1);
    frm(32'h00080000, 3'h2, 5'h03, 3'h4);
    wb(1'b0, ccr_pkg::REG_ACCEPT_OFS, 32'h0);
    chk("acc_cnt", rd_data, 32'h1);
    wb(1'b0, ccr_pkg::REG_DROP_OFS, 32'h0);
    chk("drop_cnt", rd_data, 32'h1);
    host_u.put(4'h0, 2, 16'h0000);
    frm(32'h00080000, 3'h2, 5'h03, 3'h3);
    chk("miss_irq", MISS_IRQ, 1'b1);
    chk("w12_out", CTX_W12_OUT, 16'h2000);
    chk("fecn_idle", FECN_CNT_INC, 1'b0);
    wb(1'b1, ccr_pkg::REG_CTRL_OFS, 32'h2);
    frm(32'h10000000, 3'h2, 5'h03, 3'h3);
    chk("miss_irq_off", MISS_IRQ, 1'b0);
    host_u.put(4'h0, 2, 16'h8000);
    frm(32'h10000000, 3'h2, 5'h02, 3'h3);
    frm(32'h10000000, 3'h2, 5'h0b, 3'h2);
    host_u.put(4'h0, 2, 16'h8b00);
    frm(32'h00080000, 3'h3, 5'h07, 3'h4);
    chk("err_flags", {RX_FRAME_ERROR, RX_KEEP_HEADER, RX_STORE_FCS,
        RX_WORD0_CONG_WE}, 4'he);
    chk("raw_fecn", FECN_CNT_INC, 1'b1);
    wb(1'b0, ccr_pkg::REG_STATUS_OFS, 32'h0);
    chk("status", rd_data, 32'h9);
    host_u.put(4'h0, 2, 16'h8400);
    frm(32'h10000000, 3'h2, 5'h03, 3'h4);
    chk("irq_dis", RX_IRQ, 1'b0);
    host_u.put(4'h0, 2, 16'h8000);
    host_u.put(4'h0, 3, 16'hffa9);
    host_u.put(4'h5, 4, 16'h7e44);
    host_u.put(4'h5, 5, 16'hbeee);
    frm(32'h10000000, 3'h2, 5'h03, 3'h4);
    chk("shr_ring", {RING_ENTRY_IDX, RING_SLOT}, 20'hffabf);
    chk("shr_base", RING_BASE, 24'h44beee);
    chk("shr_cnt", {RX_CONG_CNT_INC, CONG_CNT_IDX}, 14'h3ff5);
    host_u.put(4'h0, 0, 16'h2000);
    host_u.put(4'h0, 1, 16'hd5e0);
    nxt(13'h1abc);
    host_u.put(4'h0, 0, 16'h0000);
    nxt(13'h0001);
    host_u.put(4'h0, 6, 16'h1810);
    host_u.put(4'h0, 7, 16'h0000);
    tx(1'b0, 32'h181a0000);
    host_u.put(4'h0, 6, 16'h182f);
    host_u.put(4'h0, 7, 16'h0001);
    tx(1'b1, 32'h182f0001);
    report_and_stop();
  end
endmodule : ccr_rx_ctrl_tb_top
bind ccr_rx_ctrl ccr_rx_ctrl_chk chk_u (.*);
